/* rtl/rpcil_core.sv */
// seven-stage pipeline with loop-register and condition interlocks
// assumes a same-clock issuer and a classic wishbone master
// Behaviour
// [RULE1] instructions step D, AD, AC1, AC2, R, X, W one stage per cycle unless held
// [RULE2] loading block counter one also loads its save copy
// [RULE3] block repeat reading save copy waits for an X-stage load of it
// [RULE4] single repeat reading computed count waits for its X-stage memory load
// [RULE5] immediate loads of block counter or computed count happen in AD
// [RULE6] software should reschedule or use immediates to avoid these stalls
// [RULE7] conditions are evaluated in R by default
// [RULE8] whole conditional evaluates its condition in AD
// [RULE9] partial conditional evaluates in X, or in R when guarding a memory write
// [RULE10] conditional repeat evaluates its condition in X
// [RULE11] an R-stage test waits one cycle behind an X-stage write
// [RULE12] software should write condition registers a cycle early
// [RULE13] whole conditional true runs AD to W; false suppresses everything
// [RULE14] whole conditional pointer update waits for the tested register write
// [RULE15] partial conditional gates only X; AD to R effects always happen
// [RULE16] partial conditional reads memory always, writes destination only if true
// [RULE17] single repeat loads its counter from computed count or constant in AD
// [RULE18] block repeat copies save copy into block counter in AD
// [RULE19] AD modifier after memory-guarding partial test waits two cycles
`timescale 1ns/100ps
`include "rpcil_consts.svh"
module rpcil_core import rpcil_pkg::*; (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // instruction issue
    input wire logic in_valid,
    output logic in_ready,
    input rpcil_op_t in_op,
    input rpcil_cond_t in_cond,
    input wire logic [1:0] in_src,
    input wire logic [1:0] in_dst,
    input wire logic in_wr_x,
    input wire logic in_wr_ad,
    input wire logic [`RPCIL_DW-1:0] in_value,
    // retire side
    output logic retire,
    output logic mem_wr,
    output logic [`RPCIL_DW-1:0] mem_wr_data,
    output logic repeat_go,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    rpcil_desc_t pipe_reg [`RPCIL_NST];
    logic [`RPCIL_DW-1:0] creg_reg [`RPCIL_NREG];
    logic [`RPCIL_DW-1:0] block_repeat_counter_1_reg;
    logic [`RPCIL_DW-1:0] block_repeat_save_1_reg;
    logic [`RPCIL_DW-1:0] computed_single_repeat_reg;
    logic [`RPCIL_DW-1:0] single_repeat_counter_reg;
    logic [`RPCIL_DW-1:0] stalls_reg;
    logic repeat_go_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic stall_ad, stall_r, hold_any, ad_live, x_live, sw_wr;
    logic [2:0] hold_top;
    rpcil_desc_t in_desc, d_ad, d_r, d_x, d_w;

    function automatic logic [2:0] eval_st(rpcil_desc_t d);
        if (d.op == OP_COND_REP) begin
            return `RPCIL_ST_X; // [RULE10]
        end
        case (d.cond)
            C_TEST: return `RPCIL_ST_R; // [RULE7]
            C_WHOLE: return `RPCIL_ST_AD; // [RULE8]
            C_PART: return `RPCIL_ST_X; // [RULE9]
            C_PART_MEM: return `RPCIL_ST_R; // [RULE9]
            default: return `RPCIL_ST_NONE;
        endcase
    endfunction : eval_st

    function automatic logic cnow(logic [1:0] s);
        return creg_reg[s] != `RPCIL_ZERO;
    endfunction : cnow

    // an X-stage writer of r still between stage lo and X
    function automatic logic xwr_pend(logic [1:0] r, logic [2:0] lo);
        logic p;
        p = 1'b0;
        for (int j = int'(lo); j <= int'(`RPCIL_ST_X); j++) begin
            if (pipe_reg[j].valid && pipe_reg[j].wr_x && pipe_reg[j].dst == r) begin
                p = 1'b1;
            end
        end
        return p;
    endfunction : xwr_pend

    function automatic logic ld_pend(rpcil_op_t o);
        logic p;
        p = 1'b0;
        for (int j = int'(`RPCIL_ST_AC1); j <= int'(`RPCIL_ST_X); j++) begin
            if (pipe_reg[j].valid && pipe_reg[j].op == o) begin
                p = 1'b1;
            end
        end
        return p;
    endfunction : ld_pend

    // memory-guarding partial test of r not yet evaluated
    function automatic logic pmem_pend(logic [1:0] r);
        logic p;
        p = 1'b0;
        for (int j = int'(`RPCIL_ST_AC1); j <= int'(`RPCIL_ST_AC2); j++) begin
            if (pipe_reg[j].valid && pipe_reg[j].cond == C_PART_MEM && pipe_reg[j].src == r) begin
                p = 1'b1;
            end
        end
        return p;
    endfunction : pmem_pend

    function automatic rpcil_desc_t adv(rpcil_desc_t d, logic [2:0] st);
        rpcil_desc_t n;
        n = d;
        if (eval_st(d) == st) begin
            n.cond_ok = cnow(d.src);
        end
        return n;
    endfunction : adv

    always_comb begin
        in_desc = '0;
        in_desc.valid = 1'b1;
        in_desc.op = in_op;
        in_desc.cond = in_cond;
        in_desc.src = in_src;
        in_desc.dst = in_dst;
        in_desc.wr_x = in_wr_x;
        in_desc.wr_ad = in_wr_ad;
        in_desc.value = in_value;
        in_desc.cond_ok = 1'b1;
    end

    assign d_ad = pipe_reg[`RPCIL_ST_AD];
    assign d_r = pipe_reg[`RPCIL_ST_R];
    assign d_x = pipe_reg[`RPCIL_ST_X];
    assign d_w = pipe_reg[`RPCIL_ST_W];

    // hazard detection; a stall ends once the writer reaches W, or once the memory-guarding test reaches R
    always_comb begin
        stall_ad = d_ad.valid && (
            (d_ad.op == OP_BLK_REP && ld_pend(OP_LD_CNT_MEM)) || // [RULE3]
            (d_ad.op == OP_SREP_REG && ld_pend(OP_LD_CSREP_MEM)) || // [RULE4]
            (eval_st(d_ad) == `RPCIL_ST_AD && xwr_pend(d_ad.src, `RPCIL_ST_AC1)) || // [RULE14]
            (d_ad.wr_ad && pmem_pend(d_ad.dst))); // [RULE19]
        stall_r = d_r.valid && eval_st(d_r) == `RPCIL_ST_R && xwr_pend(d_r.src, `RPCIL_ST_X); // [RULE11]
        hold_any = stall_ad || stall_r;
        hold_top = stall_r ? `RPCIL_ST_R : `RPCIL_ST_AD;
    end

    assign in_ready = !hold_any;

    // AD effects happen once, on the cycle the instruction leaves AD
    // a process, not an assign, so a change of the tested register re-evaluates it
    always_comb begin
        ad_live = ce && d_ad.valid && !hold_any && (d_ad.cond != C_WHOLE || cnow(d_ad.src)); // [RULE13]
    end

    always_comb begin
        x_live = ce && d_x.valid;
        case (d_x.cond)
            C_WHOLE, C_PART_MEM: x_live = x_live && d_x.cond_ok; // [RULE13]
            C_PART: x_live = x_live && cnow(d_x.src); // [RULE15] [RULE16]
            default: x_live = x_live;
        endcase
    end

    // stages above the held one keep moving, a bubble fills the gap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `RPCIL_NST; i++) begin
                pipe_reg[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 1; i < `RPCIL_NST; i++) begin
                if (!hold_any || i > int'(hold_top) + 1) begin
                    pipe_reg[i] <= adv(pipe_reg[i-1], 3'(i - 1)); // [RULE1]
                end else if (i == int'(hold_top) + 1) begin
                    pipe_reg[i] <= '0;
                end
            end
            if (!hold_any) begin
                pipe_reg[0] <= in_valid ? in_desc : '0;
            end
        end
    end

    assign sw_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[1:0] == 2'h3;

    // later program order wins: software, then X, then AD
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            block_repeat_counter_1_reg <= `RPCIL_ZERO;
            block_repeat_save_1_reg <= `RPCIL_ZERO;
        end else if (ce) begin
            if (sw_wr && wb_adr_i == `RPCIL_A_BLOCK_REPEAT_COUNTER_1) begin
                block_repeat_counter_1_reg <= wb_dat_i[`RPCIL_DW-1:0]; // [RULE2]
                block_repeat_save_1_reg <= wb_dat_i[`RPCIL_DW-1:0];
            end
            if (x_live && d_x.op == OP_LD_CNT_MEM) begin
                block_repeat_counter_1_reg <= d_x.value; // [RULE2]
                block_repeat_save_1_reg <= d_x.value;
            end
            if (ad_live && d_ad.op == OP_LD_CNT_IMM) begin
                block_repeat_counter_1_reg <= d_ad.value; // [RULE5] [RULE2]
                block_repeat_save_1_reg <= d_ad.value;
            end else if (ad_live && d_ad.op == OP_BLK_REP) begin
                block_repeat_counter_1_reg <= block_repeat_save_1_reg; // [RULE18]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            computed_single_repeat_reg <= `RPCIL_ZERO;
        end else if (ce) begin
            if (sw_wr && wb_adr_i == `RPCIL_A_CSREP) begin
                computed_single_repeat_reg <= wb_dat_i[`RPCIL_DW-1:0];
            end
            if (x_live && d_x.op == OP_LD_CSREP_MEM) begin
                computed_single_repeat_reg <= d_x.value; // [RULE4]
            end
            if (ad_live && d_ad.op == OP_LD_CSREP_IMM) begin
                computed_single_repeat_reg <= d_ad.value; // [RULE5]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            single_repeat_counter_reg <= `RPCIL_ZERO;
        end else if (ad_live && d_ad.op == OP_SREP_REG) begin
            single_repeat_counter_reg <= computed_single_repeat_reg; // [RULE17]
        end else if (ad_live && d_ad.op == OP_SREP_IMM) begin
            single_repeat_counter_reg <= d_ad.value; // [RULE17]
        end
    end

    // condition registers: AD pointer step, X data write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < `RPCIL_NREG; k++) begin
                creg_reg[k] <= `RPCIL_ZERO;
            end
        end else if (ce) begin
            if (x_live && d_x.wr_x) begin
                creg_reg[d_x.dst] <= d_x.value; // [RULE16]
            end
            if (ad_live && d_ad.wr_ad) begin
                creg_reg[d_ad.dst] <= creg_reg[d_ad.dst] + 16'h0001; // [RULE15]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            repeat_go_reg <= 1'b0;
            stalls_reg <= `RPCIL_ZERO;
        end else if (ce) begin
            if (d_x.valid && d_x.op == OP_COND_REP) begin
                repeat_go_reg <= cnow(d_x.src); // [RULE10]
            end
            if (hold_any) begin
                stalls_reg <= stalls_reg + 16'h0001;
            end
        end
    end

    assign retire = d_w.valid;
    assign mem_wr = d_w.valid && d_w.cond == C_PART_MEM && d_w.cond_ok; // [RULE9]
    assign mem_wr_data = d_w.value;
    assign repeat_go = repeat_go_reg;

    // one wait state; unmapped offsets answer zero and drop writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else if (ce) begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            dat_reg <= 32'h00000000;
            case (wb_adr_i)
                `RPCIL_A_BLOCK_REPEAT_COUNTER_1: dat_reg[`RPCIL_DW-1:0] <= block_repeat_counter_1_reg;
                `RPCIL_A_BLOCK_REPEAT_SAVE_1: dat_reg[`RPCIL_DW-1:0] <= block_repeat_save_1_reg;
                `RPCIL_A_CSREP: dat_reg[`RPCIL_DW-1:0] <= computed_single_repeat_reg;
                `RPCIL_A_SRCNT: dat_reg[`RPCIL_DW-1:0] <= single_repeat_counter_reg;
                `RPCIL_A_STALLS: dat_reg[`RPCIL_DW-1:0] <= stalls_reg;
                `RPCIL_A_STAT: begin
                    dat_reg[`RPCIL_SB_AD] <= stall_ad;
                    dat_reg[`RPCIL_SB_R] <= stall_r;
                    dat_reg[`RPCIL_SB_RGO] <= repeat_go_reg;
                end
                default: begin
                    if (wb_adr_i >= `RPCIL_A_CREG && wb_adr_i <= `RPCIL_A_CREG_LAST) begin
                        dat_reg[`RPCIL_DW-1:0] <= creg_reg[wb_adr_i[3:2]];
                    end
                end
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence save_load_young;
        d_ad.valid && d_ad.op == OP_BLK_REP && pipe_reg[`RPCIL_ST_AC1].valid
            && pipe_reg[`RPCIL_ST_AC1].op == OP_LD_CNT_MEM;
    endsequence
    sequence ce_run4;
        ce [*4];
    endsequence

    save_stall_a: assert property (save_load_young ##0 ce_run4 |-> $past(stall_ad, 3) && $past(stall_ad, 2) // [RULE3]
        && $past(stall_ad) && stall_ad ##1 !stall_ad)
        else $error("block repeat not held four cycles behind save load");
    mirror_load_a: assert property (x_live && d_x.op == OP_LD_CNT_MEM
        |=> block_repeat_counter_1_reg == block_repeat_save_1_reg) // [RULE2]
        else $error("block counter and save copy differ after load");
    count_stall_a: assert property (d_ad.valid && d_ad.op == OP_SREP_REG
        && d_x.valid && d_x.op == OP_LD_CSREP_MEM |-> stall_ad && !in_ready) // [RULE4]
        else $error("single repeat read computed count before its load");
    imm_ad_a: assert property (ad_live && d_ad.op == OP_LD_CSREP_IMM
        |=> computed_single_repeat_reg == $past(d_ad.value)) // [RULE5]
        else $error("immediate computed count load missed AD");
    srep_load_a: assert property (ad_live && d_ad.op == OP_SREP_REG
        |=> single_repeat_counter_reg == $past(computed_single_repeat_reg)) // [RULE17]
        else $error("repeat counter not loaded from computed count");
    blk_copy_a: assert property (ad_live && d_ad.op == OP_BLK_REP
        |=> block_repeat_counter_1_reg == $past(block_repeat_save_1_reg)) // [RULE18]
        else $error("block repeat did not copy save copy");
    r_stall_a: assert property (ce && d_r.valid && d_r.cond == C_TEST && d_x.valid && d_x.wr_x
        && d_x.dst == d_r.src |-> stall_r ##1 (!stall_r || !ce)) // [RULE11]
        else $error("read stage test not held exactly one cycle");
    part_order_a: assert property (d_ad.valid && d_ad.wr_ad && pipe_reg[`RPCIL_ST_AC1].valid
        && pipe_reg[`RPCIL_ST_AC1].cond == C_PART_MEM && pipe_reg[`RPCIL_ST_AC1].src == d_ad.dst
        && ce |-> stall_ad ##1 stall_ad) // [RULE19]
        else $error("AD modifier overtook memory-guarding test");
    whole_false_a: assert property (ce && d_ad.valid && !hold_any && d_ad.cond == C_WHOLE
        && !cnow(d_ad.src) && d_ad.wr_ad && !(x_live && d_x.wr_x)
        |=> creg_reg[$past(d_ad.dst)] == $past(creg_reg[d_ad.dst])) // [RULE13]
        else $error("false whole conditional changed a pointer");
    part_ad_a: assert property (ce && d_ad.valid && !hold_any && d_ad.cond == C_PART && d_ad.wr_ad
        && !(x_live && d_x.wr_x) |=> creg_reg[$past(d_ad.dst)] == $past(creg_reg[d_ad.dst]) + 16'h0001) // [RULE15]
        else $error("partial conditional skipped its AD update");
    step_a: assert property (ce && !hold_any && pipe_reg[0].valid
        |=> pipe_reg[`RPCIL_ST_AD] == $past(pipe_reg[0])) // [RULE1]
        else $error("instruction did not step from D to AD");
endmodule : rpcil_core

/* rtl/rpcil_consts.svh */
// constants for the repeat and condition interlock block
// included by the package and by the core; definitions only
`ifndef RPCIL_CONSTS_SVH
`define RPCIL_CONSTS_SVH
`define RPCIL_DW 16
`define RPCIL_NREG 4
`define RPCIL_ZERO 16'h0000
// pipeline stage indices
`define RPCIL_ST_D 3'h0
`define RPCIL_ST_AD 3'h1
`define RPCIL_ST_AC1 3'h2
`define RPCIL_ST_AC2 3'h3
`define RPCIL_ST_R 3'h4
`define RPCIL_ST_X 3'h5
`define RPCIL_ST_W 3'h6
`define RPCIL_ST_NONE 3'h7
`define RPCIL_NST 7
// register byte offsets
`define RPCIL_A_BLOCK_REPEAT_COUNTER_1 8'h00
`define RPCIL_A_BLOCK_REPEAT_SAVE_1 8'h04
`define RPCIL_A_CSREP 8'h08
`define RPCIL_A_SRCNT 8'h0c
`define RPCIL_A_STAT 8'h10
`define RPCIL_A_STALLS 8'h14
`define RPCIL_A_CREG 8'h20
`define RPCIL_A_CREG_LAST 8'h2c
// status bit positions
`define RPCIL_SB_AD 0
`define RPCIL_SB_R 1
`define RPCIL_SB_RGO 2
`endif

/* rtl/rpcil_pkg.sv */
// types shared by the interlock core and its bench
// assumes rpcil_consts.svh sits beside it on the include path
`include "rpcil_consts.svh"
package rpcil_pkg;
    typedef enum logic [3:0] {
        OP_PLAIN, OP_LD_CNT_MEM, OP_LD_CNT_IMM, OP_LD_CSREP_MEM, OP_LD_CSREP_IMM,
        OP_BLK_REP, OP_SREP_REG, OP_SREP_IMM, OP_COND_REP
    } rpcil_op_t;
    typedef enum logic [2:0] {
        C_NONE, C_TEST, C_WHOLE, C_PART, C_PART_MEM
    } rpcil_cond_t;
    typedef struct packed {
        logic valid;
        rpcil_op_t op;
        rpcil_cond_t cond;
        logic [1:0] src;
        logic [1:0] dst;
        logic wr_x;
        logic wr_ad;
        logic [`RPCIL_DW-1:0] value;
        logic cond_ok;
    } rpcil_desc_t;
endpackage : rpcil_pkg

/* testbench/rpcil_issuer.sv */
// program stream model: queues instructions and offers them on the issue port
// assumes the bench pushes from a clocked process and that ce stays high
`timescale 1ns/100ps
`include "rpcil_consts.svh"
module rpcil_issuer import rpcil_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // issue handshake
    input wire logic ce,
    input wire logic in_ready,
    output logic in_valid,
    output rpcil_op_t in_op,
    output rpcil_cond_t in_cond,
    output logic [1:0] in_src,
    output logic [1:0] in_dst,
    output logic in_wr_x,
    output logic in_wr_ad,
    output logic [`RPCIL_DW-1:0] in_value
);
    rpcil_desc_t q[$];
    int sp[$];

    task automatic push(input rpcil_desc_t d, input int idle);
        q.push_back(d);
        sp.push_back(idle);
    endtask : push

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            in_valid <= 1'b0;
            in_op <= OP_PLAIN;
            in_cond <= C_NONE;
            {in_src, in_dst, in_wr_x, in_wr_ad, in_value} <= '0;
        end else begin
            if (in_valid && in_ready && ce) begin
                void'(q.pop_front());
                void'(sp.pop_front());
            end
            // idle slots model a program that spaces a dependent pair apart
            if (q.size() > 0 && sp[0] == 0) begin
                in_valid <= 1'b1;
                in_op <= q[0].op;
                in_cond <= q[0].cond;
                {in_src, in_dst, in_wr_x, in_wr_ad, in_value} <= {q[0].src, q[0].dst, q[0].wr_x, q[0].wr_ad, q[0].value};
            end else begin
                // idle bus carries no operand, so it keeps toggling rather than looking stable
                in_valid <= 1'b0;
                in_value <= ~in_value;
                if (q.size() > 0) begin
                    sp[0]--;
                end
            end
        end
    end
endmodule : rpcil_issuer

/* testbench/repeat_and_condition_interlock_test.sv */
// self-checking bench for the repeat and condition interlock core
// assumes rpcil_pkg and rpcil_consts.svh compiled first; ce is held high throughout
`timescale 1ns/100ps
`include "rpcil_consts.svh"
module repeat_and_condition_interlock_test import rpcil_pkg::*;;
    logic clk, reset, ce = 1'b1, in_valid, in_ready, in_wr_x, in_wr_ad, retire, mem_wr, repeat_go, wb_ack_o;
    rpcil_op_t in_op;
    rpcil_cond_t in_cond;
    logic [1:0] in_src, in_dst, k, j, m;
    logic [15:0] in_value, mem_wr_data, v;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, wb_dat_o, r;
    int n_errors = 0, tests_run = 0, seed = 32'h6021, cyc_n = 0, rt[$], tk[$];
    logic [15:0] mw[$];

    rpcil_core uut (.clk(clk), .reset(reset), .ce(ce), .in_valid(in_valid), .in_ready(in_ready), .in_op(in_op),
        .in_cond(in_cond), .in_src(in_src), .in_dst(in_dst), .in_wr_x(in_wr_x), .in_wr_ad(in_wr_ad),
        .in_value(in_value), .retire(retire), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data), .repeat_go(repeat_go),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    rpcil_issuer src (.clk(clk), .reset(reset), .ce(ce), .in_ready(in_ready), .in_valid(in_valid), .in_op(in_op),
        .in_cond(in_cond), .in_src(in_src), .in_dst(in_dst), .in_wr_x(in_wr_x), .in_wr_ad(in_wr_ad),
        .in_value(in_value));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim

    // samples before the edge's updates land, so registered outputs are seen as the edge saw them
    always @(posedge clk) begin
        cyc_n++;
        if (retire === 1'b1) rt.push_back(cyc_n);
        if (in_valid === 1'b1 && in_ready === 1'b1) tk.push_back(cyc_n);
        if (mem_wr === 1'b1) mw.push_back(mem_wr_data);
        if (cyc_n == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd_data);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd_data = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) chk(32'h0, 32'h1, "bus answer");
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] x;
        wb(1'b0, a, 32'h0, x);
        chk(x, e, what);
    endtask : rd

    function automatic rpcil_desc_t mk(rpcil_op_t op, rpcil_cond_t c, logic [1:0] s, logic [1:0] dd, logic wx,
        logic wa, logic [15:0] val);
        return '{1'b1, op, c, s, dd, wx, wa, val, 1'b0};
    endfunction : mk

    function automatic rpcil_desc_t wr(logic [1:0] dd, logic [15:0] val);
        return mk(OP_PLAIN, C_NONE, 2'h0, dd, 1'b1, 1'b0, val);
    endfunction : wr

    // stall cycles the second instruction should see behind the first
    function automatic int stall_of(rpcil_desc_t a, rpcil_desc_t b, int idle);
        if (idle < 4 && ((a.op == OP_LD_CNT_MEM && b.op == OP_BLK_REP) || (a.op == OP_LD_CSREP_MEM &&
            b.op == OP_SREP_REG) || (a.wr_x && b.cond == C_WHOLE && a.dst == b.src))) return 4 - idle;
        if (idle == 0 && a.wr_x && (b.cond == C_TEST || b.cond == C_PART_MEM) && a.dst == b.src) return 1;
        if (idle < 2 && a.cond == C_PART_MEM && b.wr_ad && a.src == b.dst) return 2 - idle;
        return 0;
    endfunction : stall_of

    task automatic pair(input rpcil_desc_t a, input rpcil_desc_t b, input int idle);
        logic [31:0] s0, s1;
        int n, st;
        st = stall_of(a, b, idle);
        wb(1'b0, `RPCIL_A_STALLS, 32'h0, s0);
        rt.delete();
        tk.delete();
        mw.delete();
        src.push(a, 0);
        src.push(b, idle);
        n = 0;
        while (rt.size() < 2 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk(rt.size(), 2, "retire count");
        if (rt.size() == 2 && tk.size() == 2) begin
            // take is seen at the edge that loads D, retire one edge after W is entered
            chk(rt[0] - tk[0], 7, "latency");
            chk(rt[1] - rt[0], 1 + idle + st, "retire spacing");
        end
        wb(1'b0, `RPCIL_A_STALLS, 32'h0, s1);
        chk(s1 - s0, st, "stall count");
    endtask : pair

    initial begin
        reset = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0, "reset value or unmapped");
        wb(1'b1, `RPCIL_A_BLOCK_REPEAT_SAVE_1, 32'h1234, r);
        rd(`RPCIL_A_BLOCK_REPEAT_SAVE_1, 32'h0, "read-only save copy");
        wb(1'b1, `RPCIL_A_BLOCK_REPEAT_COUNTER_1, 32'h0077, r);
        rd(`RPCIL_A_BLOCK_REPEAT_SAVE_1, 32'h0077, "save follows counter");
        for (int i = 0; i < 2; i++) begin
            v = 16'($random(seed) & 32'h7fff) | 16'h1;
            k = 2'($random(seed));
            j = k ^ 2'h1;
            m = k ^ 2'h2;
            pair(mk(OP_LD_CNT_MEM, C_NONE, 0, 0, 0, 0, v), mk(OP_BLK_REP, C_NONE, 0, 0, 0, 0, 0), 0);
            rd(`RPCIL_A_BLOCK_REPEAT_COUNTER_1, {16'h0, v}, "counter from save");
            rd(`RPCIL_A_BLOCK_REPEAT_SAVE_1, {16'h0, v}, "save copy");
            pair(mk(OP_LD_CNT_MEM, C_NONE, 0, 0, 0, 0, v), mk(OP_BLK_REP, C_NONE, 0, 0, 0, 0, 0), 4);
            pair(mk(OP_LD_CNT_IMM, C_NONE, 0, 0, 0, 0, ~v), mk(OP_BLK_REP, C_NONE, 0, 0, 0, 0, 0), 0);
            rd(`RPCIL_A_BLOCK_REPEAT_COUNTER_1, {16'h0, ~v}, "counter immediate");
            pair(mk(OP_LD_CSREP_MEM, C_NONE, 0, 0, 0, 0, v), mk(OP_SREP_REG, C_NONE, 0, 0, 0, 0, 0), 0);
            rd(`RPCIL_A_SRCNT, {16'h0, v}, "repeat from computed");
            pair(mk(OP_LD_CSREP_IMM, C_NONE, 0, 0, 0, 0, ~v), mk(OP_SREP_REG, C_NONE, 0, 0, 0, 0, 0), 0);
            pair(mk(OP_SREP_IMM, C_NONE, 0, 0, 0, 0, v ^ 16'h5a), mk(OP_PLAIN, C_NONE, 0, 0, 0, 0, 0), 0);
            rd(`RPCIL_A_SRCNT, {16'h0, v ^ 16'h5a}, "repeat immediate");
            pair(wr(k, v), mk(OP_PLAIN, C_TEST, k, 0, 0, 0, 0), 0);
            pair(wr(k, v), mk(OP_PLAIN, C_TEST, k, 0, 0, 0, 0), 1);
            rd(8'(`RPCIL_A_CREG + 4 * k), {16'h0, v}, "condition reg");
            pair(wr(k, v), mk(OP_PLAIN, C_WHOLE, k, m, 1, 0, v ^ 16'h3), 0);
            rd(8'(`RPCIL_A_CREG + 4 * m), {16'h0, v ^ 16'h3}, "whole true");
            pair(wr(j, 16'h0), mk(OP_PLAIN, C_WHOLE, j, m, 1, 1, ~v), 0);
            rd(8'(`RPCIL_A_CREG + 4 * m), {16'h0, v ^ 16'h3}, "whole false");
            pair(wr(k, v), mk(OP_PLAIN, C_PART, k, m, 1, 0, 16'h0), 0);
            rd(8'(`RPCIL_A_CREG + 4 * m), 32'h0, "part true");
            pair(mk(OP_PLAIN, C_NONE, 0, 0, 0, 0, 0), mk(OP_PLAIN, C_PART, j, m, 1, 1, v), 0);
            rd(8'(`RPCIL_A_CREG + 4 * m), 32'h1, "part false");
            pair(mk(OP_PLAIN, C_PART_MEM, k, 0, 0, 0, v ^ 16'h9), mk(OP_PLAIN, C_NONE, 0, k, 0, 1, 0), 0);
            chk(mw.size() == 1 && mw[0] === (v ^ 16'h9), 1, "guarded write");
            pair(mk(OP_PLAIN, C_PART_MEM, j, 0, 0, 0, v), mk(OP_PLAIN, C_NONE, 0, 0, 0, 0, 0), 0);
            chk(mw.size(), 0, "suppressed write");
            pair(mk(OP_PLAIN, C_NONE, 0, 0, 0, 0, 0), mk(OP_COND_REP, C_NONE, k, 0, 0, 0, 0), 0);
            chk(repeat_go, 1, "repeat true");
            pair(mk(OP_PLAIN, C_NONE, 0, 0, 0, 0, 0), mk(OP_COND_REP, C_NONE, j, 0, 0, 0, 0), 0);
            chk(repeat_go, 0, "repeat false");
        end
        end_sim();
    end
endmodule : repeat_and_condition_interlock_test
